// file: src/plldr_top.sv
// Digital side of the oscillator PLL: comparator, loss, retime, divider
//
// Contract
// - Loss flag rises after 256 quiet feedback periods
// - Loss flag falls at once on transition
// - Holdover select forces internal fixed tuning
// - Loss closes amplifier feedback to unity gain
// - Comparator is latch plus XOR, duty tracks phase
// - Lock puts feedback rise mid data bit
// - Recovered clock falls mid retimed bit
// - Retimed data lags input 1.5 clocks
// - Divided output is oscillator over 2^n
// - Ratio fixed at build, disable variant allowed
// - Drive enable low tri-states four outputs
// - Holdover select defaults low via pull-down
//
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none
module plldr_top #(
    parameter int DIV_N = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins in
    input wire logic data_input,
    input wire logic feedback_clock_input,
    input wire logic holdover_select,
    input wire logic output_drive_enable,
    // Pins out
    output logic signal_loss_flag,
    output logic phase_error_output,
    output logic oscillator_output,
    output logic divided_output,
    output logic recovered_clock,
    output logic retimed_data,
    output logic outputs_oe_b,
    // Analog controls
    output logic tune_internal_sel,
    output logic amp_unity_gain
);
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    // Pin synchronisers
    logic data_s1_q;
    logic data_s2_q;
    logic data_prev_q;
    logic fb_s1_q;
    logic fb_s2_q;
    logic fb_prev_q;
    logic hold_s1_q;
    logic hold_s2_q;
    logic drv_s1_q;
    logic drv_s2_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            data_s1_q <= 1'b0;
            data_s2_q <= 1'b0;
            data_prev_q <= 1'b0;
            fb_s1_q <= 1'b0;
            fb_s2_q <= 1'b0;
            fb_prev_q <= 1'b0;
        end else begin
            data_s1_q <= data_input;
            data_s2_q <= data_s1_q;
            data_prev_q <= data_s2_q;
            fb_s1_q <= feedback_clock_input;
            fb_s2_q <= fb_s1_q;
            fb_prev_q <= fb_s2_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hold_s1_q <= plldr_pkg::HOLDOVER_RST;
            hold_s2_q <= plldr_pkg::HOLDOVER_RST;
            drv_s1_q <= plldr_pkg::DRIVE_EN_RST;
            drv_s2_q <= plldr_pkg::DRIVE_EN_RST;
        end else begin
            hold_s1_q <= holdover_select;
            hold_s2_q <= hold_s1_q;
            drv_s1_q <= output_drive_enable;
            drv_s2_q <= drv_s1_q;
        end
    end

    logic fb_rise;
    logic data_edge;
    assign fb_rise = fb_s2_q && !fb_prev_q;
    assign data_edge = data_s2_q ^ data_prev_q;

    // Phase comparator: data latched on feedback rise, XOR with live data
    logic fb_latch_q;
    logic fb_latch_d;
    logic pho_q;
    assign fb_latch_d = fb_rise ? data_s2_q : fb_latch_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fb_latch_q <= 1'b0;
            pho_q <= 1'b0;
        end else begin
            fb_latch_q <= fb_latch_d;
            pho_q <= data_s2_q ^ fb_latch_d;
        end
    end

    // Loss of signal counter on feedback periods
    logic [plldr_pkg::LOSS_CNT_W-1:0] loss_cnt_q;
    logic loss_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            loss_cnt_q <= '0;
            loss_q <= 1'b0;
        end else if (data_edge) begin
            loss_cnt_q <= '0;
            loss_q <= 1'b0;
        end else if (fb_rise && !loss_q) begin
            if (loss_cnt_q == plldr_pkg::LOSS_LAST) begin
                loss_q <= 1'b1;
            end
            loss_cnt_q <= loss_cnt_q + 1'b1;
        end
    end

    // Holdover and amplifier controls
    logic tune_int_q;
    logic unity_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tune_int_q <= 1'b0;
            unity_q <= 1'b0;
        end else begin
            tune_int_q <= hold_s2_q;
            unity_q <= loss_q;
        end
    end

    // Oscillator model: half the system clock, also the recovered clock
    logic osc_q;
    logic osc_rise;
    assign osc_rise = !osc_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= !osc_q;
        end
    end

    // Retime: sample at one clock rise, present at the next
    logic stage_q;
    logic rdata_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stage_q <= 1'b0;
            rdata_q <= 1'b0;
        end else if (osc_rise) begin
            stage_q <= data_s2_q;
            rdata_q <= stage_q;
        end
    end

    // Divider, exponent fixed at build
    logic [plldr_pkg::DIV_CNT_W-1:0] div_cnt_q;
    logic div_q;
    localparam logic [7:0] DIV_HALF_LAST =
        (DIV_N >= 1 && DIV_N <= plldr_pkg::DIV_N_MAX) ?
        8'((1 << (DIV_N - 1)) - 1) : 8'h00;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_q <= '0;
            div_q <= 1'b0;
        end else if (DIV_N >= 1 && DIV_N <= plldr_pkg::DIV_N_MAX) begin
            if (osc_rise) begin
                if (div_cnt_q == DIV_HALF_LAST) begin
                    div_cnt_q <= '0;
                    div_q <= !div_q;
                end else begin
                    div_cnt_q <= div_cnt_q + 1'b1;
                end
            end
        end
    end

    // Output enable, low while driving
    logic oe_b_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            oe_b_q <= !plldr_pkg::DRIVE_EN_RST;
        end else begin
            oe_b_q <= !drv_s2_q;
        end
    end

    // Captured words of retimed data into the FIFO
    logic capture_q;
    logic [plldr_pkg::WORD_W-1:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic word_valid_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [plldr_pkg::WORD_W-1:0] fifo_out_data;
    logic pop;
    logic ovf_q;
    logic ovf_set;
    assign pop = reg_rd && hit(reg_addr, plldr_pkg::OFF_DATA) &&
        fifo_out_valid;
    // A finished word waiting for room stalls the shifter; each bit lost
    // while stalled flags overflow
    assign ovf_set = capture_q && osc_rise && word_valid_q && !fifo_in_ready;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '0;
            bit_cnt_q <= '0;
            word_valid_q <= 1'b0;
        end else begin
            if (word_valid_q && fifo_in_ready) begin
                word_valid_q <= 1'b0;
            end
            if (capture_q && osc_rise && !ovf_set) begin
                shift_q <= {shift_q[plldr_pkg::WORD_W-2:0], stage_q};
                if (bit_cnt_q == plldr_pkg::BIT_LAST) begin
                    bit_cnt_q <= '0;
                    word_valid_q <= 1'b1;
                end else begin
                    bit_cnt_q <= bit_cnt_q + 1'b1;
                end
            end
        end
    end

    plldr_fifo #(
        .WIDTH(plldr_pkg::WORD_W),
        .DEPTH(plldr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(word_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(shift_q),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // Register writes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            capture_q <= plldr_pkg::CTRL_CAPTURE_RST;
        end else if (reg_wr && hit(reg_addr, plldr_pkg::OFF_CTRL)) begin
            capture_q <= reg_wdata[plldr_pkg::CTRL_CAPTURE_BIT];
        end
    end

    // Overflow is sticky; a new overflow wins over a clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (reg_wr && hit(reg_addr, plldr_pkg::OFF_STATUS) &&
                     reg_wdata[plldr_pkg::ST_OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    // Register reads, data one cycle after the strobe
    logic [31:0] rd_d;
    logic [31:0] rdata_bus_q;

    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit(reg_addr, plldr_pkg::OFF_CTRL)) begin
            rd_d[plldr_pkg::CTRL_CAPTURE_BIT] = capture_q;
        end else if (hit(reg_addr, plldr_pkg::OFF_STATUS)) begin
            rd_d[plldr_pkg::ST_LOSS_BIT] = loss_q;
            rd_d[plldr_pkg::ST_HOLD_BIT] = tune_int_q;
            rd_d[plldr_pkg::ST_OVF_BIT] = ovf_q;
            rd_d[plldr_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
            rd_d[plldr_pkg::ST_FULL_BIT] = !fifo_in_ready;
        end else if (hit(reg_addr, plldr_pkg::OFF_DATA)) begin
            rd_d[plldr_pkg::WORD_W-1:0] = fifo_out_valid ?
                fifo_out_data : '0;
        end else if (hit(reg_addr, plldr_pkg::OFF_LOSS_CNT)) begin
            rd_d[plldr_pkg::LOSS_CNT_W-1:0] = loss_cnt_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_bus_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_bus_q <= rd_d;
        end else begin
            rdata_bus_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_bus_q;
    assign signal_loss_flag = loss_q;
    assign phase_error_output = pho_q;
    assign oscillator_output = osc_q;
    assign divided_output = div_q;
    assign recovered_clock = osc_q;
    assign retimed_data = rdata_q;
    assign outputs_oe_b = oe_b_q;
    assign tune_internal_sel = tune_int_q;
    assign amp_unity_gain = unity_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_loss_set;
        fb_rise && !data_edge && !loss_q &&
            loss_cnt_q == plldr_pkg::LOSS_LAST |=> loss_q;
    endproperty
    a_loss_set: assert property (p_loss_set)
        else $error("loss flag not set after 256 quiet periods");

    property p_loss_early;
        !loss_q && loss_cnt_q < plldr_pkg::LOSS_LAST |=> !loss_q;
    endproperty
    a_loss_early: assert property (p_loss_early)
        else $error("loss flag set too early");

    property p_loss_clear;
        data_edge |=> !loss_q && loss_cnt_q == '0;
    endproperty
    a_loss_clear: assert property (p_loss_clear)
        else $error("transition did not clear loss state");

    property p_holdover;
        hold_s2_q |=> tune_internal_sel;
    endproperty
    a_holdover: assert property (p_holdover)
        else $error("holdover did not select internal tuning");

    property p_unity;
        $rose(loss_q) |=> amp_unity_gain ##1 amp_unity_gain || !loss_q;
    endproperty
    a_unity: assert property (p_unity)
        else $error("amplifier not closed on loss");

    property p_pho;
        1'b1 |=> phase_error_output == ($past(data_s2_q) ^ fb_latch_q);
    endproperty
    a_pho: assert property (p_pho)
        else $error("comparator output wrong after feedback rise");

    property p_latch;
        fb_rise |=> fb_latch_q == $past(data_s2_q);
    endproperty
    a_latch: assert property (p_latch)
        else $error("comparator latch missed feedback rise");

    property p_rdata_edge;
        $changed(rdata_q) |-> $rose(osc_q);
    endproperty
    a_rdata_edge: assert property (p_rdata_edge)
        else $error("retimed data moved off the clock rise");

    property p_rdata_lag;
        osc_rise |-> ##3 rdata_q == $past(data_s2_q, 3);
    endproperty
    a_rdata_lag: assert property (p_rdata_lag)
        else $error("retimed data lag is not 1.5 clocks");

    property p_div;
        $changed(div_q) |-> $past(div_cnt_q) == DIV_HALF_LAST &&
            $past(osc_rise);
    endproperty
    a_div: assert property (p_div)
        else $error("divided output toggled at wrong count");

    property p_oe;
        !drv_s2_q |=> outputs_oe_b;
    endproperty
    a_oe: assert property (p_oe)
        else $error("outputs still driven with enable low");
endmodule : plldr_top
`default_nettype wire

// file: src/plldr_pkg.sv
// Constants shared by the loss-detect, retime and divider block
`default_nettype none
package plldr_pkg;
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_LOSS_CNT = 8'h0C;
    // Control register fields
    localparam int CTRL_CAPTURE_BIT = 0;
    localparam logic CTRL_CAPTURE_RST = 1'b0;
    // Status register fields
    localparam int ST_LOSS_BIT = 0;
    localparam int ST_HOLD_BIT = 1;
    localparam int ST_OVF_BIT = 2;
    localparam int ST_EMPTY_BIT = 3;
    localparam int ST_FULL_BIT = 4;
    // Loss detector
    localparam int LOSS_PERIODS = 256;
    localparam int LOSS_CNT_W = 9;
    localparam logic [LOSS_CNT_W-1:0] LOSS_LAST =
        LOSS_CNT_W'(LOSS_PERIODS - 1);
    // Retimed data capture
    localparam int WORD_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] BIT_LAST = 4'(WORD_W - 1);
    // Divider: exponent 1..8, 0 builds the divided output disabled
    localparam int DIV_N_MAX = 8;
    localparam int DIV_CNT_W = 8;
    // Reset values of pin synchronisers, matching the pad pulls
    localparam logic DRIVE_EN_RST = 1'b1;
    localparam logic HOLDOVER_RST = 1'b0;
endpackage : plldr_pkg
`default_nettype wire

// file: src/plldr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module plldr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_C = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != DEPTH_C);
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule : plldr_fifo
`default_nettype wire

// file: dv/plldr_partner.sv
// Far-side model: NRZ data source and feedback clock divider
`default_nettype none
module plldr_partner (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Block outputs seen by the far side
    input wire logic oscillator_output,
    input wire logic outputs_oe_b,
    // Bench controls
    input wire logic stream_on,
    input wire logic flip,
    // Pins into the block
    output var logic data_input,
    output var logic feedback_clock_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic osc_seen;
    logic osc_prev;
    logic [1:0] osc_cnt;
    logic bit_phase;
    // A released output floats: show a toggling pattern, not the last value
    always_comb osc_seen = outputs_oe_b ? ~osc_prev : oscillator_output;
    // Feedback is a copy of the oscillator output divided by four
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            osc_prev <= 1'b0;
            osc_cnt <= 2'h0;
        end else begin
            osc_prev <= osc_seen;
            if (osc_seen && !osc_prev) begin
                osc_cnt <= osc_cnt + 2'h1;
            end
        end
    end
    always_comb feedback_clock_input = osc_cnt[1];
    // Alternating NRZ at the loop rate (RZ needs twice baud); flip: one edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bit_phase <= 1'b0;
            data_input <= 1'b0;
        end else begin
            bit_phase <= ~bit_phase;
            if ((stream_on && bit_phase) || flip) begin
                data_input <= ~data_input;
            end
        end
    end
endmodule : plldr_partner
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the loss-detect, retime and divider block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV_N = 3;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic holdover_select = 1'b0;
    logic output_drive_enable = 1'b1;
    logic stream_on = 1'b0;
    logic flip = 1'b0;
    logic data_input;
    logic feedback_clock_input;
    logic signal_loss_flag;
    logic phase_error_output;
    logic oscillator_output;
    logic divided_output;
    logic recovered_clock;
    logic retimed_data;
    logic outputs_oe_b;
    logic tune_internal_sel;
    logic amp_unity_gain;
    logic div_off_out;
    logic rd_prev = 1'b0;
    logic rc_prev = 1'b0;
    logic watch_on = 1'b0;
    logic rd0;
    logic [31:0] rv;
    logic [31:0] first;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    time t0;

    always #5 clk_sys = ~clk_sys;

    plldr_top #(.DIV_N(DIV_N)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .data_input(data_input),
        .feedback_clock_input(feedback_clock_input),
        .holdover_select(holdover_select),
        .output_drive_enable(output_drive_enable),
        .signal_loss_flag(signal_loss_flag),
        .phase_error_output(phase_error_output),
        .oscillator_output(oscillator_output),
        .divided_output(divided_output), .recovered_clock(recovered_clock),
        .retimed_data(retimed_data), .outputs_oe_b(outputs_oe_b),
        .tune_internal_sel(tune_internal_sel), .amp_unity_gain(amp_unity_gain)
    );

    // Build variant with the divided output switched off
    plldr_top #(.DIV_N(0)) uut_off (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .data_input(data_input),
        .feedback_clock_input(feedback_clock_input),
        .holdover_select(holdover_select),
        .output_drive_enable(output_drive_enable), .signal_loss_flag(),
        .phase_error_output(), .oscillator_output(),
        .divided_output(div_off_out), .recovered_clock(), .retimed_data(),
        .outputs_oe_b(), .tune_internal_sel(), .amp_unity_gain()
    );

    plldr_partner partner (
        .clk_sys(clk_sys), .rst_b(rst_b),
        .oscillator_output(oscillator_output), .outputs_oe_b(outputs_oe_b),
        .stream_on(stream_on), .flip(flip), .data_input(data_input),
        .feedback_clock_input(feedback_clock_input)
    );

    task automatic test_done;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : wait_cyc

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand in the cycle after the strobe; taken at its end
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : reg_read

    task automatic check_reg(input logic [7:0] a, input logic [31:0] m,
                             input logic [31:0] exp);
        reg_read(a, rv);
        cmp_word(rv & m, exp);
    endtask : check_reg

    task automatic pulse_flip;
        flip <= 1'b1;
        @(posedge clk_sys);
        flip <= 1'b0;
    endtask : pulse_flip

    // One data edge as the feedback falls, then k quiet feedback periods
    task automatic quiet_run(input int k);
        @(posedge feedback_clock_input);
        wait_cyc(3);
        pulse_flip;
        repeat (k) @(posedge feedback_clock_input);
        wait_cyc(6);
    endtask : quiet_run

    always @(posedge clk_sys) begin
        if (watch_on && retimed_data !== rd_prev) begin
            cmp_bit(recovered_clock && !rc_prev, 1'b1);
        end
        rd_prev <= retimed_data;
        rc_prev <= recovered_clock;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            test_done;
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        wait_cyc(5);
        cmp_bit(tune_internal_sel, 1'b0);
        cmp_bit(outputs_oe_b, 1'b0);
        check_reg(plldr_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h0);
        check_reg(8'h10, 32'hFFFFFFFF, 32'h0);
        @(posedge oscillator_output);
        t0 = $time;
        @(posedge oscillator_output);
        cmp_word(32'(($time - t0) / 10), 32'h2);
        @(posedge divided_output);
        t0 = $time;
        @(posedge divided_output);
        cmp_word(32'(($time - t0) / 10), 32'(2 << DIV_N));
        cmp_bit(div_off_out, 1'b0);
        holdover_select <= 1'b1;
        wait_cyc(5);
        cmp_bit(tune_internal_sel, 1'b1);
        check_reg(plldr_pkg::OFF_STATUS, 32'h2, 32'h2);
        holdover_select <= 1'b0;
        output_drive_enable <= 1'b0;
        wait_cyc(5);
        cmp_bit(tune_internal_sel, 1'b0);
        cmp_bit(outputs_oe_b, 1'b1);
        output_drive_enable <= 1'b1;
        wait_cyc(5);
        cmp_bit(outputs_oe_b, 1'b0);
        @(posedge feedback_clock_input);
        wait_cyc(3);
        pulse_flip;
        wait_cyc(5);
        cmp_bit(phase_error_output, 1'b1);
        wait_cyc(7);
        cmp_bit(phase_error_output, 1'b0);
        quiet_run(200);
        cmp_bit(signal_loss_flag, 1'b0);
        check_reg(plldr_pkg::OFF_LOSS_CNT, 32'h1FF, 32'h0C8);
        quiet_run(255);
        cmp_bit(signal_loss_flag, 1'b0);
        @(posedge feedback_clock_input);
        wait_cyc(7);
        cmp_bit(signal_loss_flag, 1'b1);
        cmp_bit(amp_unity_gain, 1'b1);
        check_reg(plldr_pkg::OFF_STATUS, 32'h1, 32'h1);
        pulse_flip;
        wait_cyc(5);
        cmp_bit(signal_loss_flag, 1'b0);
        wait_cyc(1);
        cmp_bit(amp_unity_gain, 1'b0);
        wait_cyc(4);
        rd0 = retimed_data;
        pulse_flip;
        n = 0;
        while (retimed_data === rd0 && n < 12) begin
            @(posedge clk_sys);
            n++;
        end
        cmp_bit(n >= 4 && n <= 8, 1'b1);
        watch_on <= 1'b1;
        // Stream settles through the synchronisers before capture starts
        stream_on <= 1'b1;
        wait_cyc(8);
        reg_write(plldr_pkg::OFF_CTRL, 32'h1);
        check_reg(plldr_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h1);
        n = 0;
        do begin
            reg_read(plldr_pkg::OFF_STATUS, rv);
            n++;
        end while (rv[plldr_pkg::ST_FULL_BIT] !== 1'b1 && n < 80);
        wait_cyc(40);
        check_reg(plldr_pkg::OFF_STATUS, 32'h1C, 32'h14);
        reg_write(plldr_pkg::OFF_CTRL, 32'h0);
        // Eight stored words plus the one held at the FIFO input
        for (int i = 0; i < plldr_pkg::FIFO_DEPTH + 1; i++) begin
            reg_read(plldr_pkg::OFF_DATA, rv);
            if (i == 0) begin
                first = rv;
            end
            cmp_bit(first === 32'hAA || first === 32'h55, 1'b1);
            cmp_word(rv, first);
        end
        check_reg(plldr_pkg::OFF_STATUS, 32'h18, 32'h08);
        check_reg(plldr_pkg::OFF_DATA, 32'hFFFFFFFF, 32'h0);
        reg_write(plldr_pkg::OFF_STATUS, 32'h4);
        check_reg(plldr_pkg::OFF_STATUS, 32'h4, 32'h0);
        stream_on <= 1'b0;
        test_done;
    end
endmodule : tb_top
`default_nettype wire
